/* File: design/dpr_host_ctrl.sv */
`timescale 1ns/1ps
`include "dpr_map.svh"
module dpr_host_ctrl #(
  parameter int DW          = 16,
  parameter int AW          = 12,
  parameter int READ_CYC    = `DPR_READ_CYC,
  parameter int SETTLE_CYC  = `DPR_SETTLE_CYC,
  parameter int WRITE_CYC   = `DPR_WRITE_CYC,
  parameter int RECOVER_CYC = `DPR_RECOVER_CYC,
  parameter int GAP_CYC     = `DPR_GAP_CYC
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [7:0]          swAddr,
  input  wire logic [31:0]         swWdata,
  input  wire logic                swWrite,
  input  wire logic                swRead,
  output logic      [31:0]         swRdata,
  output logic                     portSelectN,
  output logic                     tokenLatchSelectN,
  output logic                     readWriteN,
  output logic                     outDriveN,
  output logic                     highLaneSelectN,
  output logic                     lowLaneSelectN,
  output logic      [AW-1:0]       memAddr,
  input  wire logic [DW-1:0]       dataIn,
  output logic      [DW-1:0]       dataOut,
  output logic      [DW-1:0]       dataOe,
  input  wire logic                mailboxIntN,
  input  wire logic                collisionN,
  output dpr_pkg::dpr_state_e      ctrlState
);
  import dpr_pkg::*;

  localparam int LOW_W = DW / 2;
  localparam logic [7:0] READ_C8    = 8'(READ_CYC);
  localparam logic [7:0] SETTLE_C8  = 8'(SETTLE_CYC);
  localparam logic [7:0] WRITE_C8   = 8'(WRITE_CYC);
  localparam logic [7:0] RECOVER_C8 = 8'(RECOVER_CYC);
  localparam logic [7:0] GAP_C8     = 8'(GAP_CYC);

  dpr_state_e    state;
  dpr_op_e       op;
  logic [AW-1:0] addrReg;
  logic [DW-1:0] wdataReg;
  logic [DW-1:0] rdata;
  logic [1:0]    laneEn;
  logic          abortReq;
  logic          done;
  logic          collided;
  logic          won;
  logic          driveData;
  logic [DW-1:0] laneMask;
  logic [7:0]    gapCnt;
  logic [7:0]    oeCnt;

  assign ctrlState = state;

  // software port decode
  wire           ctrlHit    = swWrite && (swAddr == `DPR_REG_CTRL);
  wire [2:0]     opField    = swWdata[2:0];
  wire           opValid    = (opField <= 3'h4);
  wire           abortHit   = ctrlHit && swWdata[`DPR_CTRL_ABORT];
  // an abort-only write never starts a new access
  wire           goStart    = ctrlHit && opValid && !abortHit && (state == S_IDLE);
  dpr_op_e       startOp;
  assign startOp = dpr_op_e'(opField);
  wire           startToken = (opField >= 3'h2);
  wire           startRead  = (startOp == DPR_OP_READ) || (startOp == DPR_OP_TOKEN_READ);
  wire           startTWr   = (startOp == DPR_OP_TOKEN_WRITE) || (startOp == DPR_OP_TOKEN_TAKE);
  wire           isToken    = (op != DPR_OP_READ) && (op != DPR_OP_WRITE);
  wire           takeAgain  = (op == DPR_OP_TOKEN_TAKE) && !won && !abortReq;
  wire           tokenBit   = wdataReg[0] && (startOp != DPR_OP_TOKEN_TAKE);

  // cycle timer sequencing
  logic       tmrDone;
  wire        tmrLoad = goStart || ((state != S_IDLE) && tmrDone);
  wire [7:0]  idleCyc = startRead ? READ_C8 : (startToken ? WRITE_C8 : SETTLE_C8);
  wire [7:0]  settCyc = abortReq ? RECOVER_C8 : (collisionN ? WRITE_C8 : SETTLE_C8);
  wire [7:0]  postCyc = isToken ? GAP_C8 : RECOVER_C8;
  wire [7:0]  tmrCount = (state == S_IDLE)    ? idleCyc :
                         (state == S_SETTLE)  ? settCyc :
                         (state == S_RECOVER) ? READ_C8 : postCyc;
  wire        readSample = (state == S_READ) && tmrDone;

  dpr_cycle_timer #(
    .W       (8)
  ) u_timer (
    .clock   (clock),
    .rst     (rst),
    .load    (tmrLoad),
    .count   (tmrCount),
    .expired (tmrDone)
  );

  // lane gating per data bit; token write drives every line
  generate
    for (genvar i = 0; i < DW; i++) begin : g_lane
      // follow the latched lane pins, not the live register
      assign laneMask[i] = (i < LOW_W) ? !lowLaneSelectN : !highLaneSelectN;
      assign dataOe[i]   = driveData && (isToken || laneMask[i]);
    end
  endgenerate

  wire [DW-1:0] readValue = isToken ? dataIn : (dataIn & laneMask);

  // software registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addrReg  <= '0;
      wdataReg <= '0;
      laneEn   <= `DPR_LANES_RESET;
    end else if (swWrite) begin
      if (swAddr == `DPR_REG_ADDR) begin
        addrReg <= swWdata[AW-1:0];
      end
      if (swAddr == `DPR_REG_WDATA) begin
        wdataReg <= swWdata[DW-1:0];
      end
      if (swAddr == `DPR_REG_LANES) begin
        laneEn <= swWdata[1:0];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      abortReq <= 1'b0;
    end else begin
      abortReq <= (abortReq || abortHit) && (state != S_IDLE);
    end
  end

  wire [31:0] statusWord = {26'h0, !collisionN, !mailboxIntN, won, collided, done, (state != S_IDLE)};
  wire [31:0] readMux = (swAddr == `DPR_REG_CTRL)   ? {29'h0, op} :
                        (swAddr == `DPR_REG_ADDR)   ? 32'(addrReg) :
                        (swAddr == `DPR_REG_WDATA)  ? 32'(wdataReg) :
                        (swAddr == `DPR_REG_LANES)  ? {30'h0, laneEn} :
                        (swAddr == `DPR_REG_STATUS) ? statusWord :
                        (swAddr == `DPR_REG_RDATA)  ? 32'(rdata) : 32'h0000_0000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      swRdata <= 32'h0000_0000;
    end else begin
      swRdata <= swRead ? readMux : 32'h0000_0000;
    end
  end

  // port sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state             <= S_IDLE;
      op                <= DPR_OP_READ;
      portSelectN       <= 1'b1;
      tokenLatchSelectN <= 1'b1;
      readWriteN        <= 1'b1;
      outDriveN         <= 1'b1;
      highLaneSelectN   <= 1'b1;
      lowLaneSelectN    <= 1'b1;
      driveData         <= 1'b0;
      dataOut           <= '0;
      memAddr           <= '0;
      rdata             <= '0;
      done              <= 1'b0;
      collided          <= 1'b0;
      won               <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (goStart) begin
            op       <= startOp;
            done     <= 1'b0;
            collided <= 1'b0;
            won      <= 1'b0;
            memAddr  <= addrReg;
            dataOut  <= startToken ? {DW{tokenBit}} : wdataReg;
            if (startToken) begin
              tokenLatchSelectN <= 1'b0;
              highLaneSelectN   <= 1'b1;
              lowLaneSelectN    <= 1'b1;
            end else begin
              portSelectN     <= 1'b0;
              highLaneSelectN <= !laneEn[1];
              lowLaneSelectN  <= !laneEn[0];
            end
            readWriteN <= !startTWr;
            outDriveN  <= !startRead;
            driveData  <= startTWr;
            state      <= startRead ? S_READ : (startToken ? S_WRITE : S_SETTLE);
          end
        end
        S_SETTLE: begin
          // select held with write strobe off until collision input settles
          if (tmrDone) begin
            if (abortReq) begin
              portSelectN <= 1'b1;
              state       <= S_RECOVER;
            end else if (!collisionN) begin
              collided <= 1'b1;
            end else begin
              readWriteN <= 1'b0;
              driveData  <= 1'b1;
              state      <= S_WRITE;
            end
          end
        end
        S_WRITE: begin
          if (tmrDone) begin
            readWriteN        <= 1'b1;
            portSelectN       <= 1'b1;
            tokenLatchSelectN <= 1'b1;
            state             <= S_RECOVER;
          end
        end
        S_READ: begin
          if (tmrDone) begin
            rdata <= readValue;
            if (!isToken && !collisionN) begin
              collided <= 1'b1;
            end
            if ((op == DPR_OP_TOKEN_TAKE) && !dataIn[0]) begin
              won <= 1'b1;
            end
            outDriveN         <= 1'b1;
            portSelectN       <= 1'b1;
            tokenLatchSelectN <= 1'b1;
            state             <= S_RECOVER;
          end
        end
        S_RECOVER: begin
          if (tmrDone) begin
            driveData       <= 1'b0;
            highLaneSelectN <= 1'b1;
            lowLaneSelectN  <= 1'b1;
            if (takeAgain) begin
              tokenLatchSelectN <= 1'b0;
              outDriveN         <= 1'b0;
              state             <= S_READ;
            end else begin
              done  <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // helper counters for the checks below
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gapCnt <= 8'hFF;
      oeCnt  <= 8'h00;
    end else begin
      if (!tokenLatchSelectN && !readWriteN) begin
        gapCnt <= 8'h00;
      end else if (gapCnt != 8'hFF) begin
        gapCnt <= gapCnt + 8'h01;
      end
      if (outDriveN) begin
        oeCnt <= 8'h00;
      end else if (oeCnt != 8'hFF) begin
        oeCnt <= oeCnt + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_select_exclusive: assert property (!(!portSelectN && !tokenLatchSelectN))
    else $error("port select and token select both active");

  a_token_lanes_idle: assert property (!tokenLatchSelectN |-> portSelectN && highLaneSelectN && lowLaneSelectN)
    else $error("token access with port select or lanes active");

  a_read_has_select: assert property (!outDriveN |-> readWriteN && (portSelectN != tokenLatchSelectN))
    else $error("output drive without exactly one select");

  a_token_read_pins: assert property ((state == S_READ) && isToken |-> !outDriveN && !tokenLatchSelectN)
    else $error("token read without token select and output drive");

  a_write_settled: assert property ($fell(readWriteN) && !portSelectN |->
                                    $past(collisionN) && !$past(portSelectN, SETTLE_CYC))
    else $error("memory write started before collision settled");

  a_token_gap_held: assert property ($fell(outDriveN) && !tokenLatchSelectN |-> gapCnt >= GAP_C8)
    else $error("token read too soon after token write");

  a_read_wait_flow: assert property (readSample |-> !outDriveN && (oeCnt >= READ_C8 - 8'h01))
    else $error("read data sampled before access and flowthrough delay");

  a_lane_gate_write: assert property (!portSelectN && !readWriteN |->
                                      $stable(highLaneSelectN) && $stable(lowLaneSelectN) &&
                                      (dataOe[0] == !lowLaneSelectN) && (dataOe[DW-1] == !highLaneSelectN))
    else $error("data drive does not follow lane selects");

  a_token_bit_all: assert property (!tokenLatchSelectN && !readWriteN |-> (&dataOe) && (dataOut == {DW{dataOut[0]}}))
    else $error("token write not driving one bit on all lines");

  a_no_bus_fight: assert property (!outDriveN |-> (dataOe == '0))
    else $error("host drives data while device output enabled");

  c_mem_write: cover property ($fell(readWriteN) && !portSelectN);
  c_collision_wait: cover property ((state == S_SETTLE) && tmrDone && !collisionN);
  c_take_poll: cover property (readSample && (op == DPR_OP_TOKEN_TAKE) && dataIn[0]);
  c_take_won: cover property ((state == S_RECOVER) && tmrDone && won);

endmodule

/* File: design/dpr_map.svh */
`ifndef DPR_MAP_SVH
`define DPR_MAP_SVH
// Contract
// - opposite-port read valid after flowthrough delay
// - memory read needs select and output drive
// - token access uses token select, not select
// - delay writes until collision input settled
// - select inactive during token access, upper address ignored
// - token gap before reading back latch

// software register byte offsets
`define DPR_REG_CTRL    8'h00
`define DPR_REG_ADDR    8'h04
`define DPR_REG_WDATA   8'h08
`define DPR_REG_LANES   8'h0C
`define DPR_REG_STATUS  8'h10
`define DPR_REG_RDATA   8'h14

// field positions and reset values
`define DPR_CTRL_ABORT  8
`define DPR_LANES_RESET 2'h3

// timing figures in ns and derived cycle counts
`define DPR_CLK_NS      4
`define DPR_ACCESS_NS   20
`define DPR_FLOW_NS     30
`define DPR_SETTLE_NS   20
`define DPR_WRITE_NS    20
`define DPR_RECOVER_NS  8
`define DPR_GAP_NS      12
`define DPR_CEIL(ns) (((ns) + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_READ_CYC ((`DPR_CEIL(`DPR_ACCESS_NS) > `DPR_CEIL(`DPR_FLOW_NS)) ? \
  `DPR_CEIL(`DPR_ACCESS_NS) : `DPR_CEIL(`DPR_FLOW_NS))
`define DPR_SETTLE_CYC  `DPR_CEIL(`DPR_SETTLE_NS)
`define DPR_WRITE_CYC   `DPR_CEIL(`DPR_WRITE_NS)
`define DPR_RECOVER_CYC `DPR_CEIL(`DPR_RECOVER_NS)
`define DPR_GAP_CYC     `DPR_CEIL(`DPR_GAP_NS)

`endif

/* File: design/dpr_pkg.sv */
package dpr_pkg;

  typedef enum logic [2:0] {
    DPR_OP_READ,
    DPR_OP_WRITE,
    DPR_OP_TOKEN_WRITE,
    DPR_OP_TOKEN_READ,
    DPR_OP_TOKEN_TAKE
  } dpr_op_e;

  typedef enum logic [2:0] {
    S_IDLE,
    S_SETTLE,
    S_WRITE,
    S_READ,
    S_RECOVER
  } dpr_state_e;

endpackage

/* File: design/dpr_cycle_timer.sv */
`timescale 1ns/1ps
module dpr_cycle_timer #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              expired
);

  logic [W-1:0] remain;

  // expires in the count-th cycle after the load edge
  assign expired = (remain == W'(1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (remain != '0) begin
      remain <= remain - W'(1);
    end
  end

endmodule

/* File: tb/dpr_dev_model.sv */
`timescale 1ns/1ps
module dpr_dev_model #(
  parameter int ACC_NS = 16
) (
  input  wire logic        clock,
  input  wire logic        portSelectN,
  input  wire logic        tokenLatchSelectN,
  input  wire logic        readWriteN,
  input  wire logic        outDriveN,
  input  wire logic        highLaneSelectN,
  input  wire logic        lowLaneSelectN,
  input  wire logic [11:0] memAddr,
  input  wire logic [15:0] hostData,
  input  wire logic [15:0] hostOe,
  input  wire logic        busyForce,
  output logic      [15:0] wireLvl,
  output logic             mailboxIntN,
  output logic             collisionN,
  output logic             peerIntN
);
  logic [15:0] mem [4096];
  logic [1:0]  owner [8];
  logic [7:0]  pend [3];
  logic [15:0] floatLvl = 16'h5A5A;
  logic [15:0] tokHold = 16'hFFFF;
  logic [15:0] wrData, wrMask;
  logic [11:0] wrAddr;
  logic [2:0]  tokAt;
  logic        hostInt = 1'b0;
  logic        peerInt = 1'b0;
  logic        rdValid = 1'b0;
  logic        tokBit;
  wire  [15:0] laneMask = {{8{~highLaneSelectN}}, {8{~lowLaneSelectN}}};
  wire         memWr = !portSelectN && !readWriteN;
  wire         memRd = !portSelectN && !outDriveN && readWriteN;
  wire         tokWr = !tokenLatchSelectN && !readWriteN;
  wire         tokRd = !tokenLatchSelectN && !outDriveN && readWriteN;
  wire  [15:0] devOe = !rdValid ? 16'h0 : memRd ? laneMask : {16{tokRd}};
  wire  [15:0] devOut = memRd ? mem[memAddr] : tokHold;

  assign wireLvl = (hostOe & hostData) | (~hostOe & devOe & devOut) | (~hostOe & ~devOe & floatLvl);
  assign collisionN = !busyForce;
  assign mailboxIntN = !hostInt;
  assign peerIntN = !peerInt;

  initial begin
    foreach (owner[i]) owner[i] = 2'd0;
    foreach (pend[i]) pend[i] = 8'h0;
  end
  // undriven lines wander instead of keeping the last value
  always @(posedge clock) floatLvl <= ~floatLvl;
  always @(memRd or tokRd) begin
    rdValid = 1'b0;
    if (memRd || tokRd) rdValid <= #(ACC_NS) 1'b1;
  end
  // capture while the strobe is low, so release order does not matter
  always @* begin
    if (memWr) begin
      wrAddr = memAddr;
      wrData = wireLvl;
      wrMask = laneMask;
    end
    if (tokWr) begin
      tokBit = wireLvl[0];
      tokAt = memAddr[2:0];
    end
  end
  always @(negedge memWr) begin
    if (!busyForce) begin
      mem[wrAddr] = (mem[wrAddr] & ~wrMask) | (wrData & wrMask);
      if (wrAddr == 12'hFFF) peerInt = 1'b1;
    end
  end
  always @(posedge memRd) begin
    #1;
    if (memAddr == 12'hFFE && !busyForce) hostInt = 1'b0;
  end
  always @(posedge tokRd) begin
    #1;
    tokHold = {16{owner[memAddr[2:0]] != 2'd1}};
  end
  always @(negedge tokWr) token_write(2'd1, tokAt, tokBit);

  // side 1 is the host port, side 2 the far port
  task automatic token_write(input logic [1:0] side, input logic [2:0] idx, input logic val);
    logic [1:0] peer;
    peer = 2'd3 - side;
    if (!val) begin
      if (owner[idx] == 2'd0) owner[idx] = side;
      else if (owner[idx] == peer) pend[side][idx] = 1'b1;
    end else if (owner[idx] == side) begin
      owner[idx] = pend[peer][idx] ? peer : 2'd0;
      pend[peer][idx] = 1'b0;
    end else pend[side][idx] = 1'b0;
  endtask
  task automatic far_mem_write(input logic [11:0] a, input logic [15:0] d);
    mem[a] = d;
    if (a == 12'hFFE) hostInt = 1'b1;
  endtask
endmodule

/* File: tb/test_dual_port_ram_arbitration.sv */
`timescale 1ns/1ps
`include "dpr_map.svh"
module test_dual_port_ram_arbitration;
  import dpr_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  swAddr = 8'h0;
  logic [31:0] swWdata = 32'h0;
  logic        swWrite = 1'b0;
  logic        swRead = 1'b0;
  logic        busyForce = 1'b0;
  logic [31:0] swRdata, st, rd;
  logic        portSelectN, tokenLatchSelectN, readWriteN, outDriveN, highLaneSelectN, lowLaneSelectN;
  logic        mailboxIntN, collisionN, peerIntN;
  logic [11:0] memAddr;
  logic [15:0] dataOut, dataOe, wireLvl;
  dpr_state_e  ctrlState;
  int          miscompares = 0;
  int          totalChecks = 0;
  int          cycles = 0;

  dpr_host_ctrl dut_u (.clock, .rst, .swAddr, .swWdata, .swWrite, .swRead, .swRdata, .portSelectN,
    .tokenLatchSelectN, .readWriteN, .outDriveN, .highLaneSelectN, .lowLaneSelectN, .memAddr,
    .dataIn(wireLvl), .dataOut, .dataOe, .mailboxIntN, .collisionN, .ctrlState);
  dpr_dev_model dev_u (.clock, .portSelectN, .tokenLatchSelectN, .readWriteN, .outDriveN,
    .highLaneSelectN, .lowLaneSelectN, .memAddr, .hostData(dataOut), .hostOe(dataOe), .busyForce,
    .wireLvl, .mailboxIntN, .collisionN, .peerIntN);

  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      giveVerdict();
    end
  end

  task automatic giveVerdict();
    if (miscompares == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic swWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    swAddr <= a;
    swWdata <= d;
    swWrite <= 1'b1;
    @(posedge clock);
    swWrite <= 1'b0;
  endtask
  task automatic swRd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    swAddr <= a;
    swRead <= 1'b1;
    @(posedge clock);
    swRead <= 1'b0;
    @(negedge clock);
    d = swRdata;
  endtask
  task automatic startOp(input logic [31:0] op, input logic [31:0] a, input logic [31:0] wd);
    swWr(`DPR_REG_ADDR, a);
    swWr(`DPR_REG_WDATA, wd);
    swWr(`DPR_REG_CTRL, op);
  endtask
  task automatic waitIdle();
    st = 32'h1;
    for (int i = 0; i < 100 && st[0]; i++) swRd(`DPR_REG_STATUS, st);
    check({31'h0, st[0]}, 32'h0);
  endtask
  task automatic runOp(input logic [31:0] op, input logic [31:0] a, input logic [31:0] wd);
    startOp(op, a, wd);
    waitIdle();
  endtask

  task automatic tReset();
    check({16'h0, dataOe}, 32'h0);
    check({29'h0, ctrlState}, {29'h0, S_IDLE});
    swRd(`DPR_REG_LANES, rd);
    check(rd, 32'h3);
    swRd(8'hFC, rd);
    check(rd, 32'h0);
  endtask
  task automatic tMemory();
    runOp(32'h1, 32'h5, 32'h1234);
    check({16'h0, dev_u.mem[5]}, 32'h1234);
    swWr(`DPR_REG_LANES, 32'h1);
    runOp(32'h1, 32'h5, 32'hABCD);
    check({16'h0, dev_u.mem[5]}, 32'h12CD);
    swWr(`DPR_REG_LANES, 32'h2);
    runOp(32'h0, 32'h5, 32'h0);
    swRd(`DPR_REG_RDATA, rd);
    check(rd, 32'h1200);
    swWr(`DPR_REG_LANES, 32'h3);
    runOp(32'h0, 32'h5, 32'h0);
    swRd(`DPR_REG_RDATA, rd);
    check(rd, 32'h12CD);
  endtask
  task automatic tMailbox();
    dev_u.far_mem_write(12'hFFE, 16'hAA);
    swRd(`DPR_REG_STATUS, st);
    check(st & 32'h10, 32'h10);
    runOp(32'h1, 32'hFFF, 32'h5);
    check({31'h0, peerIntN}, 32'h0);
    runOp(32'h0, 32'hFFF, 32'h0);
    swRd(`DPR_REG_RDATA, rd);
    check(rd, 32'h5);
    check({31'h0, peerIntN}, 32'h0);
    runOp(32'h0, 32'hFFE, 32'h0);
    swRd(`DPR_REG_RDATA, rd);
    check(rd, 32'hAA);
    swRd(`DPR_REG_STATUS, st);
    check(st & 32'h10, 32'h0);
  endtask
  task automatic tCollision();
    dev_u.far_mem_write(12'hFFE, 16'h55);
    @(posedge clock);
    busyForce <= 1'b1;
    runOp(32'h0, 32'hFFE, 32'h0);
    swRd(`DPR_REG_STATUS, st);
    check(st & 32'h34, 32'h34);
    startOp(32'h1, 32'h5, 32'h7777);
    repeat (4) swRd(`DPR_REG_STATUS, st);
    check(st & 32'h5, 32'h5);
    check({31'h0, readWriteN}, 32'h1);
    check({29'h0, ctrlState}, {29'h0, S_SETTLE});
    check({16'h0, dev_u.mem[5]}, 32'h12CD);
    @(posedge clock);
    busyForce <= 1'b0;
    waitIdle();
    check({16'h0, dev_u.mem[5]}, 32'h7777);
  endtask
  task automatic tToken();
    runOp(32'h4, 32'hFF3, 32'h0);
    swRd(`DPR_REG_STATUS, st);
    check(st & 32'h8, 32'h8);
    check({30'h0, dev_u.owner[3]}, 32'h1);
    dev_u.token_write(2'd2, 3'd3, 1'b0);
    runOp(32'h2, 32'hFF3, 32'hFFFF_FFFF);
    check({30'h0, dev_u.owner[3]}, 32'h2);
    runOp(32'h3, 32'h3, 32'h0);
    swRd(`DPR_REG_RDATA, rd);
    check(rd, 32'hFFFF);
    // only the token bit is zero
    runOp(32'h2, 32'h3, 32'hFFFF_FFFE);
    dev_u.token_write(2'd2, 3'd3, 1'b1);
    runOp(32'h3, 32'h3, 32'h0);
    swRd(`DPR_REG_RDATA, rd);
    check(rd, 32'h0);
    dev_u.token_write(2'd2, 3'd6, 1'b0);
    startOp(32'h4, 32'h6, 32'h0);
    repeat (8) swRd(`DPR_REG_STATUS, st);
    check(st & 32'h9, 32'h1);
    swWr(`DPR_REG_CTRL, 32'h100);
    waitIdle();
    check(st & 32'h9, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    tReset();
    tMemory();
    tMailbox();
    tCollision();
    tToken();
    giveVerdict();
  end
endmodule
